// File: hw/tlic_cfg.svh
// Register addresses, field positions, reset values and cycle counts of the interrupt block.
`ifndef TLIC_CFG_SVH
`define TLIC_CFG_SVH
`define TLIC_ADDR_CENTRAL_CONTROL_REGISTER 8'he6
`define TLIC_ADDR_EDGE_SELECT_REGISTER 8'hf2
`define TLIC_ADDR_EXT_PENDING_REGISTER 8'hf3
`define TLIC_ADDR_EXT_MASK_REGISTER 8'hf4
`define TLIC_ADDR_EXT_VECTOR_REGISTER 8'hf6
`define TLIC_ADDR_NESTING_LEVEL_REGISTER 8'hf7
`define TLIC_CENTRAL_CONTROL_REGISTER_RST 8'h87
`define TLIC_EDGE_SELECT_REGISTER_RST 8'h00
`define TLIC_EXT_PENDING_REGISTER_RST 8'h00
`define TLIC_EXT_MASK_REGISTER_RST 8'h00
`define TLIC_EXT_VECTOR_REGISTER_RST 8'h06
`define TLIC_CENTRAL_CONTROL_REGISTER_GCEN 7
`define TLIC_CENTRAL_CONTROL_REGISTER_TOP_PENDING_FLAG 6
`define TLIC_CENTRAL_CONTROL_REGISTER_TLI 5
`define TLIC_CENTRAL_CONTROL_REGISTER_IEN 4
`define TLIC_CENTRAL_CONTROL_REGISTER_IAM 3
`define TLIC_EXT_VECTOR_REGISTER_TEDGE 3
`define TLIC_EXT_VECTOR_REGISTER_TSRC 2
`define TLIC_EXT_VECTOR_REGISTER_A0SRC 1
`define TLIC_NESTING_LEVEL_REGISTER_LOCK 7
`define TLIC_ARB_PERIOD 3'd5
`define TLIC_IMC_BASE 5'd18
`define TLIC_IMC_STACK 5'd2
`define TLIC_IMC_SEG 5'd2
`define TLIC_IMC_WAKE 5'd1
`endif

// File: hw/tlic_pkg.sv
// Types shared by the interrupt control block.
package tlic_pkg;
    typedef enum logic [1:0] {
        TLIC_IDLE = 2'b00,
        TLIC_ACK = 2'b01,
        TLIC_WAIT = 2'b11,
        TLIC_IMC = 2'b10
    } tlic_state_t;
    typedef logic [2:0] tlic_level_t;
endpackage : tlic_pkg

// File: hw/tlic_edge.sv
// Pin synchroniser with qualified edge detection for one interrupt input.
`timescale 1ns/10ps
module tlic_edge (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pin,
    input wire logic rise_sel,
    output logic evt
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;
    wire agree = (s2_reg == s3_reg);
    wire moved = agree && (s3_reg != lvl_reg);

    // A level counts only once the last two stages agree, so one edge fires once.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                lvl_reg <= s3_reg;
            end
        end
    end

    assign evt = moved && (rise_sel ? s3_reg : !s3_reg);
endmodule : tlic_edge

// File: hw/tlic_top.sv
// Top level and external interrupt control with arbitration and machine cycle timing.
`timescale 1ns/10ps
`include "tlic_cfg.svh"

// Functional notes
// - Top source is the non-maskable pin when select is high, else watchdog end.
// - Pin source detects rising edge when edge select set, falling when clear.
// - Selected top event sets the top pending flag.
// - Maskable path needs top pending, top enable and global enable together.
// - Unmaskable lock is set-only, bypasses global enable, cleared only by reset.
// - Running top routine blocks every interrupt, DMA and further top requests.
// - Top handling never touches global enable, priority level or nesting state.
// - Top acknowledge clears top pending; software may set it.
// - Peripheral pending set by trigger, set or cleared by software, readable.
// - Peripheral request needs mask, pending and global enable all set.
// - Channel priority is three bits; level seven is never acknowledged.
// - Requests sampled every five clocks; acknowledge adds one clock.
// - Abort current instruction if nothing written, else wait for its end.
// - External channel response spans 26 to 55 clocks depending on instruction.
// - Top level response spans 22 to 51 clocks depending on instruction.
// - Machine cycle is 18 clocks, plus 2 stack, 2 segment, 1 wake.
// - Machine cycle clears global enable, return sets it, except for top.
// - Arbitration mode zero is concurrent, one is nested.
// - Current priority level is three bits, updated by hardware in nested mode.
// - Edge select zero picks falling edge, one picks rising edge.
// - External pending set on edge, cleared on acknowledge, software settable.
// - External request needs mask, pending and global enable all set.
module tlic_top
    import tlic_pkg::*;
#(
    parameter int NPER = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] ext_pin,
    input wire logic nmi_pin,
    input wire logic wdg_eoc,
    input wire logic [7:0] ext_pair_level,
    input wire logic [NPER-1:0] per_trig,
    input wire logic [NPER-1:0] per_sw_set,
    input wire logic [NPER-1:0] per_sw_clr,
    input wire logic [NPER-1:0] per_mask,
    input wire logic [3*NPER-1:0] per_level,
    output logic [NPER-1:0] per_pending,
    input wire logic cpu_ei,
    input wire logic cpu_di,
    input wire logic cpu_iret,
    input wire logic cpu_wrote,
    input wire logic cpu_instr_end,
    input wire logic cpu_wfi,
    input wire logic stack_in_rf,
    input wire logic seg_save_en,
    output logic irq_abort,
    output logic imc_active,
    output logic irq_start,
    output logic [4:0] irq_src,
    output logic irq_top,
    output logic dma_block,
    output logic mft_enable
);
    localparam int NSRC = 8 + NPER;

    function automatic tlic_level_t ext_level(input logic [7:0] pairs, input int ch);
        ext_level = {pairs[2*(ch/2)+1], pairs[2*(ch/2)], ch[0]};
    endfunction : ext_level

    function automatic logic [2:0] lowest_held(input logic [6:0] held);
        lowest_held = 3'h7;
        for (int k = 6; k >= 0; k--) begin
            if (held[k]) begin
                lowest_held = 3'(k);
            end
        end
    endfunction : lowest_held

    tlic_state_t state_reg;
    tlic_state_t state_next;
    logic [2:0] arb_cnt_reg;
    logic [4:0] imc_cnt_reg;
    logic [4:0] imc_len_reg;
    logic gcen_reg;
    logic top_pending_flag_reg;
    logic tli_reg;
    logic ien_reg;
    logic iam_reg;
    tlic_level_t cpl_reg;
    logic [7:0] edge_select_register_reg;
    logic [7:0] ext_pending_register_reg;
    logic [7:0] ext_mask_register_reg;
    logic [7:0] ext_vector_register_reg;
    logic lock_reg;
    logic [6:0] hold_reg;
    logic [NPER-1:0] per_pend_reg;
    logic top_active_reg;
    logic grant_top_reg;
    logic [4:0] grant_idx_reg;
    tlic_level_t grant_lvl_reg;
    logic [7:0] rdata_reg;
    logic [7:0] pin_evt;
    logic nmi_evt;
    logic [7:0] ext_evt;
    logic [NSRC-1:0] src_req;
    logic [NSRC-1:0][2:0] src_lvl;
    logic best_ok;
    tlic_level_t best_lvl;
    logic [4:0] best_idx;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ext
            tlic_edge u_edge (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .pin(ext_pin[g]),
                .rise_sel(edge_select_register_reg[g]),
                .evt(pin_evt[g])
            );
            assign src_lvl[g] = ext_level(ext_pair_level, g);
        end
        for (g = 0; g < NPER; g++) begin : g_per
            assign src_lvl[8+g] = per_level[3*g +: 3];
        end
    endgenerate

    tlic_edge u_nmi_edge (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin(nmi_pin),
        .rise_sel(ext_vector_register_reg[`TLIC_EXT_VECTOR_REGISTER_TEDGE]),
        .evt(nmi_evt)
    );

    wire wr_central_control_register = reg_wr && (reg_addr == `TLIC_ADDR_CENTRAL_CONTROL_REGISTER);
    wire wr_edge_select_register = reg_wr && (reg_addr == `TLIC_ADDR_EDGE_SELECT_REGISTER);
    wire wr_ext_pending_register = reg_wr && (reg_addr == `TLIC_ADDR_EXT_PENDING_REGISTER);
    wire wr_ext_mask_register = reg_wr && (reg_addr == `TLIC_ADDR_EXT_MASK_REGISTER);
    wire wr_ext_vector_register = reg_wr && (reg_addr == `TLIC_ADDR_EXT_VECTOR_REGISTER);
    wire wr_nesting_level_register = reg_wr && (reg_addr == `TLIC_ADDR_NESTING_LEVEL_REGISTER);

    wire top_evt = ext_vector_register_reg[`TLIC_EXT_VECTOR_REGISTER_TSRC] ? nmi_evt : wdg_eoc;
    assign ext_evt = {pin_evt[7:1], ext_vector_register_reg[`TLIC_EXT_VECTOR_REGISTER_A0SRC] ? pin_evt[0] : wdg_eoc};

    wire top_req = top_pending_flag_reg && ((tli_reg && ien_reg) || lock_reg);
    assign src_req = {per_mask & per_pend_reg, ext_mask_register_reg & ext_pending_register_reg} & {NSRC{ien_reg}};

    // Lowest level wins; a source must beat the current level, so level seven never does.
    always_comb begin
        best_ok = 1'b0;
        best_lvl = cpl_reg;
        best_idx = 5'h00;
        for (int i = 0; i < NSRC; i++) begin
            if (src_req[i] && (src_lvl[i] < best_lvl) && (src_lvl[i] != 3'h7)) begin
                best_ok = 1'b1;
                best_lvl = src_lvl[i];
                best_idx = 5'(i);
            end
        end
    end

    wire sample = (arb_cnt_reg == `TLIC_ARB_PERIOD - 3'd1);
    wire grant_any = sample && !top_active_reg && (top_req || best_ok);
    wire ack_now = (state_reg == TLIC_WAIT) && (!cpu_wrote || cpu_instr_end);
    wire ack_top = ack_now && grant_top_reg;
    wire ack_chan = ack_now && !grant_top_reg;
    wire nested = iam_reg;
    wire ret_chan = cpu_iret && !top_active_reg;
    wire [NSRC-1:0] ack_vec = ack_chan ? (NSRC'(1) << grant_idx_reg) : '0;
    wire [2:0] pop_lvl = lowest_held(hold_reg);
    wire [4:0] imc_len = `TLIC_IMC_BASE + (stack_in_rf ? `TLIC_IMC_STACK : 5'd0)
        + (seg_save_en ? `TLIC_IMC_SEG : 5'd0) + (cpu_wfi ? `TLIC_IMC_WAKE : 5'd0);

    // Sequencer: sample, one acknowledge clock, abort or wait, then the machine cycle.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TLIC_IDLE: begin
                if (grant_any) begin
                    state_next = TLIC_ACK;
                end
            end
            TLIC_ACK: begin
                state_next = TLIC_WAIT;
            end
            TLIC_WAIT: begin
                if (ack_now) begin
                    state_next = TLIC_IMC;
                end
            end
            TLIC_IMC: begin
                if (imc_cnt_reg == 5'd0) begin
                    state_next = TLIC_IDLE;
                end
            end
            default: begin
                state_next = TLIC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= TLIC_IDLE;
            arb_cnt_reg <= 3'd0;
            imc_cnt_reg <= 5'd0;
            imc_len_reg <= 5'd0;
            grant_top_reg <= 1'b0;
            grant_idx_reg <= 5'h00;
            grant_lvl_reg <= 3'h7;
            top_active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            arb_cnt_reg <= sample ? 3'd0 : arb_cnt_reg + 3'd1;
            if (state_reg == TLIC_IDLE && grant_any) begin
                grant_top_reg <= top_req;
                grant_idx_reg <= best_idx;
                grant_lvl_reg <= best_lvl;
            end
            if (ack_now) begin
                imc_cnt_reg <= imc_len - 5'd1;
                imc_len_reg <= imc_len;
            end else if (imc_cnt_reg != 5'd0) begin
                imc_cnt_reg <= imc_cnt_reg - 5'd1;
            end
            if (ack_top) begin
                top_active_reg <= 1'b1;
            end else if (cpu_iret) begin
                top_active_reg <= 1'b0;
            end
        end
    end

    // Central control: top pending merges events so a set beats a clear; for global enable a channel acknowledge clear beats a set.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gcen_reg <= 1'(`TLIC_CENTRAL_CONTROL_REGISTER_RST >> `TLIC_CENTRAL_CONTROL_REGISTER_GCEN);
            top_pending_flag_reg <= 1'b0;
            tli_reg <= 1'b0;
            ien_reg <= 1'b0;
            iam_reg <= 1'b0;
            cpl_reg <= 3'h7;
            hold_reg <= 7'h00;
            lock_reg <= 1'b0;
        end else begin
            top_pending_flag_reg <= top_evt || (wr_central_control_register && reg_wdata[`TLIC_CENTRAL_CONTROL_REGISTER_TOP_PENDING_FLAG])
                || (top_pending_flag_reg && !ack_top);
            if (wr_nesting_level_register && reg_wdata[`TLIC_NESTING_LEVEL_REGISTER_LOCK]) begin
                lock_reg <= 1'b1;
            end
            if (ack_chan) begin
                ien_reg <= 1'b0;
            end else if (ret_chan || cpu_ei) begin
                ien_reg <= 1'b1;
            end else if (cpu_di) begin
                ien_reg <= 1'b0;
            end else if (wr_central_control_register) begin
                ien_reg <= reg_wdata[`TLIC_CENTRAL_CONTROL_REGISTER_IEN];
            end
            if (ack_chan && nested) begin
                cpl_reg <= grant_lvl_reg;
                if (cpl_reg != 3'h7) begin
                    hold_reg[cpl_reg] <= 1'b1;
                end
            end else if (ret_chan && nested) begin
                cpl_reg <= pop_lvl;
                if (pop_lvl != 3'h7) begin
                    hold_reg[pop_lvl] <= 1'b0;
                end
            end else if (wr_central_control_register) begin
                cpl_reg <= reg_wdata[2:0];
            end
            if (wr_central_control_register) begin
                gcen_reg <= reg_wdata[`TLIC_CENTRAL_CONTROL_REGISTER_GCEN];
                tli_reg <= reg_wdata[`TLIC_CENTRAL_CONTROL_REGISTER_TLI];
                iam_reg <= reg_wdata[`TLIC_CENTRAL_CONTROL_REGISTER_IAM];
            end
        end
    end

    // External and peripheral channel registers.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            edge_select_register_reg <= `TLIC_EDGE_SELECT_REGISTER_RST;
            ext_pending_register_reg <= `TLIC_EXT_PENDING_REGISTER_RST;
            ext_mask_register_reg <= `TLIC_EXT_MASK_REGISTER_RST;
            ext_vector_register_reg <= `TLIC_EXT_VECTOR_REGISTER_RST;
            per_pend_reg <= '0;
        end else begin
            ext_pending_register_reg <= ext_evt | (wr_ext_pending_register ? reg_wdata : 8'h00)
                | (ext_pending_register_reg & ~ack_vec[7:0]);
            per_pend_reg <= per_trig | per_sw_set
                | (per_pend_reg & ~per_sw_clr & ~ack_vec[NSRC-1:8]);
            if (wr_edge_select_register) begin
                edge_select_register_reg <= reg_wdata;
            end
            if (wr_ext_mask_register) begin
                ext_mask_register_reg <= reg_wdata;
            end
            if (wr_ext_vector_register) begin
                ext_vector_register_reg <= reg_wdata;
            end
        end
    end

    wire [7:0] central_control_register_view = {gcen_reg, top_pending_flag_reg, tli_reg, ien_reg, iam_reg, cpl_reg};
    wire [7:0] rd_mux = (reg_addr == `TLIC_ADDR_CENTRAL_CONTROL_REGISTER) ? central_control_register_view :
        (reg_addr == `TLIC_ADDR_EDGE_SELECT_REGISTER) ? edge_select_register_reg :
        (reg_addr == `TLIC_ADDR_EXT_PENDING_REGISTER) ? ext_pending_register_reg :
        (reg_addr == `TLIC_ADDR_EXT_MASK_REGISTER) ? ext_mask_register_reg :
        (reg_addr == `TLIC_ADDR_EXT_VECTOR_REGISTER) ? ext_vector_register_reg :
        (reg_addr == `TLIC_ADDR_NESTING_LEVEL_REGISTER) ? {lock_reg, hold_reg} : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end
    end

    assign reg_rdata = rdata_reg;
    assign per_pending = per_pend_reg;
    assign irq_abort = (state_reg == TLIC_WAIT) && !cpu_wrote;
    assign imc_active = (state_reg == TLIC_IMC);
    assign irq_start = (state_reg == TLIC_IMC) && (imc_cnt_reg == 5'd0);
    assign irq_src = grant_idx_reg;
    assign irq_top = grant_top_reg;
    assign dma_block = top_active_reg;
    assign mft_enable = gcen_reg;

    logic [4:0] imc_cyc_reg;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || ack_now) begin
            imc_cyc_reg <= 5'd0;
        end else if (imc_active) begin
            imc_cyc_reg <= imc_cyc_reg + 5'd1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_ack_path;
        (state_reg == TLIC_ACK) ##1 (state_reg == TLIC_WAIT);
    endsequence
    sequence s_sample_win;
        (state_reg == TLIC_IDLE) && grant_any;
    endsequence

    a_top_pending_flag_set: assert property (top_evt |=> top_pending_flag_reg)
        else $error("top pending not set after top event");
    a_lock_sticky: assert property (lock_reg |=> lock_reg)
        else $error("unmaskable lock cleared without reset");
    a_top_blocks: assert property (top_active_reg && state_reg == TLIC_IDLE |=>
        state_reg == TLIC_IDLE)
        else $error("request granted during top routine");
    a_top_keeps_ien: assert property (ack_top && !cpu_ei && !cpu_di && !reg_wr |=>
        ien_reg == $past(ien_reg) && cpl_reg == $past(cpl_reg))
        else $error("top acknowledge changed enable or level");
    a_ien_cleared: assert property (ack_chan |=> !ien_reg)
        else $error("channel acknowledge left global enable set");
    a_arb_sample: assert property (s_sample_win |-> arb_cnt_reg == 3'd4 ##1 s_ack_path)
        else $error("grant outside the five clock sample or ack path wrong");
    a_imc_length: assert property (irq_start |-> imc_cyc_reg == imc_len_reg - 5'd1)
        else $error("machine cycle length wrong");
    a_abort_clean: assert property (state_reg == TLIC_WAIT && !cpu_wrote |=> imc_active)
        else $error("no abort without a write");
    a_wait_write: assert property (state_reg == TLIC_WAIT && cpu_wrote && !cpu_instr_end
        |=> state_reg == TLIC_WAIT)
        else $error("aborted after a write");
    a_ext_pend: assert property ((|ext_evt) |=> (ext_pending_register_reg & $past(ext_evt)) == $past(ext_evt))
        else $error("external edge lost");
    a_req_gate: assert property (state_reg == TLIC_IDLE && grant_any && !top_req |-> ien_reg)
        else $error("channel granted with global enable clear");
    a_no_level7: assert property (state_reg == TLIC_ACK && !grant_top_reg |->
        grant_lvl_reg != 3'h7 && grant_lvl_reg < cpl_reg)
        else $error("level seven or non-winning level granted");
endmodule : tlic_top

// File: tb/tlic_core_model.sv
// Behavioural processor core and interrupt pin driver facing the interrupt block.
`timescale 1ns/10ps
module tlic_core_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wrote_cmd,
    input wire logic [7:0] pin_cmd,
    input wire logic nmi_cmd,
    output logic cpu_wrote,
    output logic cpu_instr_end,
    output logic [7:0] ext_pin,
    output logic nmi_pin
);
    logic [2:0] cnt_reg;
    initial begin
        {cpu_wrote, cpu_instr_end, nmi_pin} = 3'b001;
        ext_pin = 8'h00;
        cnt_reg = 3'h0;
    end
    // Outputs move on the falling edge so the block always samples settled levels.
    always @(negedge sys_clk) begin
        ext_pin <= pin_cmd;
        nmi_pin <= nmi_cmd;
        cpu_wrote <= wrote_cmd;
        cnt_reg <= (sys_rst || cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
        cpu_instr_end <= !sys_rst && cnt_reg == 3'h5;
    end
endmodule : tlic_core_model

// File: tb/top_level_and_external_irq_control_tb.sv
// Self-checking bench for the top level and external interrupt control block.
`timescale 1ns/10ps
`define CHK(g, e) chk_val(32'(g), 32'(e))
module top_level_and_external_irq_control_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pin_cmd = 8'h00, ext_pair_level = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, wdg_eoc = 1'b0, cpu_ei = 1'b0, cpu_di = 1'b0;
    logic cpu_iret = 1'b0, cpu_wfi = 1'b0, stack_in_rf = 1'b0, seg_save_en = 1'b0;
    logic wrote_cmd = 1'b0, nmi_cmd = 1'b1;
    logic [3:0] per_trig = 4'h0, per_sw_set = 4'h0, per_sw_clr = 4'h0, per_mask = 4'h0;
    logic [11:0] per_level = 12'hfd7;
    logic [7:0] reg_rdata, ext_pin;
    logic [3:0] per_pending;
    logic [4:0] irq_src;
    logic cpu_wrote, cpu_instr_end, nmi_pin, irq_abort, imc_active, irq_start;
    logic irq_top, dma_block, mft_enable;
    int err_total = 0;
    int compares = 0;

    always #5 sys_clk = ~sys_clk;

    tlic_core_model i_core (.sys_clk, .sys_rst, .wrote_cmd, .pin_cmd, .nmi_cmd, .cpu_wrote,
        .cpu_instr_end, .ext_pin, .nmi_pin);

    tlic_top #(.NPER(4)) i_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ext_pin, .nmi_pin, .wdg_eoc, .ext_pair_level, .per_trig, .per_sw_set,
        .per_sw_clr, .per_mask, .per_level, .per_pending, .cpu_ei, .cpu_di, .cpu_iret,
        .cpu_wrote, .cpu_instr_end, .cpu_wfi, .stack_in_rf, .seg_save_en, .irq_abort,
        .imc_active, .irq_start, .irq_src, .irq_top, .dma_block, .mft_enable);

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at time %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        `CHK(reg_rdata, e);
        cyc(1);
    endtask : rd_chk

    task automatic iret();
        cpu_iret = 1'b1;
        cyc(1);
        cpu_iret = 1'b0;
        cyc(1);
    endtask : iret

    task automatic idle_chk(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge sys_clk);
            if (imc_active !== 1'b0) seen = 1'b1;
        end
        `CHK(seen, 1'b0);
    endtask : idle_chk

    // Waits for the machine cycle to begin, then counts its clocks up to the routine start.
    task automatic serve(input logic [4:0] src, input logic top, input int len, input logic ab);
        int k;
        int n;
        logic seen;
        seen = 1'b0;
        n = 1;
        for (k = 0; k < 80 && imc_active !== 1'b1; k++) begin
            if (irq_abort === 1'b1) seen = 1'b1;
            @(negedge sys_clk);
        end
        for (k = 0; k < 40 && irq_start !== 1'b1; k++) begin
            @(negedge sys_clk);
            n++;
        end
        if (irq_start !== 1'b1) begin
            err_total++;
            print_verdict();
        end
        `CHK(n, len);
        `CHK(seen, ab);
        `CHK(irq_top, top);
        if (!top) `CHK(irq_src, src);
        cyc(1);
    endtask : serve

    task automatic t_reset();
        rd_chk(8'he6, 8'h87);
        rd_chk(8'hf2, 8'h00);
        rd_chk(8'hf3, 8'h00);
        rd_chk(8'h10, 8'h00);
    endtask : t_reset

    task automatic t_edges();
        wr(8'hf2, 8'h01);
        rd_chk(8'hf2, 8'h01);
        pin_cmd = 8'h02;
        cyc(8);
        rd_chk(8'hf3, 8'h00);
        pin_cmd = 8'h01;
        cyc(8);
        rd_chk(8'hf3, 8'h03);
        wr(8'hf3, 8'h00);
        rd_chk(8'hf3, 8'h03);
        wr(8'hf3, 8'h80);
        rd_chk(8'hf3, 8'h83);
    endtask : t_edges

    task automatic t_ext();
        wr(8'hf4, 8'h01);
        idle_chk(20);
        wrote_cmd = 1'b1;
        cpu_ei = 1'b1;
        cyc(1);
        cpu_ei = 1'b0;
        serve(5'd0, 1'b0, 18, 1'b0);
        rd_chk(8'he6, 8'h87);
        rd_chk(8'hf3, 8'h82);
        wrote_cmd = 1'b0;
        stack_in_rf = 1'b1;
        cpu_wfi = 1'b1;
        wr(8'hf4, 8'h03);
        iret();
        serve(5'd1, 1'b0, 21, 1'b1);
        cpu_wfi = 1'b0;
        rd_chk(8'hf3, 8'h80);
        iret();
        idle_chk(20);
        rd_chk(8'he6, 8'h97);
    endtask : t_ext

    task automatic t_top();
        wr(8'he6, 8'hb7);
        seg_save_en = 1'b1;
        nmi_cmd = 1'b0;
        serve(5'd0, 1'b1, 22, 1'b1);
        `CHK(dma_block, 1'b1);
        rd_chk(8'he6, 8'hb7);
        wr(8'hf4, 8'h83);
        idle_chk(20);
        iret();
        serve(5'd7, 1'b0, 22, 1'b1);
        `CHK(dma_block, 1'b0);
        rd_chk(8'he6, 8'ha7);
        wr(8'hf6, 8'h0e);
        nmi_cmd = 1'b1;
        cyc(8);
        rd_chk(8'he6, 8'he7);
    endtask : t_top

    task automatic t_lock();
        wr(8'hf7, 8'h80);
        serve(5'd0, 1'b1, 22, 1'b1);
        rd_chk(8'hf7, 8'h80);
        wr(8'hf7, 8'h00);
        rd_chk(8'hf7, 8'h80);
        iret();
        wr(8'hf6, 8'h0a);
        nmi_cmd = 1'b0;
        cyc(8);
        nmi_cmd = 1'b1;
        idle_chk(12);
        wdg_eoc = 1'b1;
        cyc(1);
        wdg_eoc = 1'b0;
        serve(5'd0, 1'b1, 22, 1'b1);
        iret();
    endtask : t_lock

    task automatic t_per();
        stack_in_rf = 1'b0;
        seg_save_en = 1'b0;
        per_mask = 4'h3;
        cpu_ei = 1'b1;
        cyc(1);
        cpu_ei = 1'b0;
        per_trig = 4'h1;
        cyc(1);
        per_trig = 4'h0;
        cyc(1);
        `CHK(per_pending, 4'h1);
        idle_chk(20);
        per_sw_clr = 4'h1;
        cyc(1);
        per_sw_clr = 4'h0;
        cyc(1);
        `CHK(per_pending, 4'h0);
        per_sw_set = 4'h4;
        cyc(1);
        per_sw_set = 4'h0;
        idle_chk(20);
        `CHK(per_pending, 4'h4);
        per_trig = 4'h2;
        cyc(1);
        per_trig = 4'h0;
        serve(5'd9, 1'b0, 18, 1'b1);
        `CHK(per_pending, 4'h4);
        rd_chk(8'he6, 8'ha7);
    endtask : t_per

    initial begin
        cyc(16);
        sys_rst = 1'b0;
        cyc(1);
        t_reset();
        t_edges();
        t_ext();
        t_top();
        t_lock();
        t_per();
        print_verdict();
    end
endmodule : top_level_and_external_irq_control_tb
